// file: hdl/slrxp_pkg.sv
package slrxp_pkg;

  // Sync code that opens every high-speed burst
  localparam logic [7:0] SLRXP_SYNC_BYTE = 8'hb8;

  // Byte clock division of the clock lane per gear
  localparam int SLRXP_DIV_GEAR8  = 4;
  localparam int SLRXP_DIV_GEAR16 = 8;

  // Packet header layout inside a 32-bit header word
  localparam int SLRXP_HDR_BITS  = 32;
  localparam int SLRXP_DT_LSB    = 0;
  localparam int SLRXP_VC_LSB    = 6;
  localparam int SLRXP_WC_LSB    = 8;
  localparam int SLRXP_ECC_LSB   = 24;
  localparam int SLRXP_DUAL_HDR_W = 64;

  // Data types from this code upward are long packets
  localparam logic [5:0] SLRXP_LONG_DT_MIN = 6'h10;

  // Reset values
  localparam logic [15:0] SLRXP_WC_RST = 16'h0000;

  typedef struct packed {
    logic [1:0]  vc;
    logic [5:0]  dt;
    logic [15:0] wc;
    logic [7:0]  ecc;
  } slrxp_hdr_t;

  localparam slrxp_hdr_t SLRXP_HDR_RST = '{vc: 2'h0, dt: 6'h00, wc: SLRXP_WC_RST, ecc: 8'h00};

  typedef enum logic [1:0] {
    PS_HUNT,
    PS_HEADER,
    PS_PAYLOAD,
    PS_TRAIL
  } slrxp_pstate_t;

endpackage

// file: hdl/slrxp_top.sv
// Function
// - Power-down input hard-resets the physical layer asynchronously
// - Byte clock is lane clock div4/div8, gated
// - Second byte clock runs only in clock-lane HS, data-lane HS if soft
// - Soft physical layer: both byte clocks identical
// - Sync flag rises at the B8 sync byte
// - Sync flag holds until LP-11 seen
// - Payload strobe only on payload, never checksum
// - Payload keeps lane byte order, checksum removed
// - Payload width is gear times lanes
// - Data type output is six bits
// - Virtual channel output is two bits
// - Word count output is sixteen bits
// - Short packet word count carries data bytes
// - Header check byte passed through unchanged
// - Second header outputs when width is 64
// - Combined 32-bit lane bytes, valid gear 8 with four or more lanes and parser on
// - Parser off: raw lane 0-2 words output
// - Capture valid follows sync flag with parser off, else low
// - Payload outputs on the free-running clock
module slrxp_top
  import slrxp_pkg::*;
#(
  parameter int NUM_LANES = 4,
  parameter int GEAR      = 8,
  parameter bit PARSER_EN = 1'b1,
  parameter bit SOFT_PHY  = 1'b1
) (
  input  wire logic                      clk,                      // Free-running byte clock
  input  wire logic                      reset_n,                  // Async system reset
  input  wire logic                      freerun_domain_rst_n,     // Pre-synchronised domain reset
  input  wire logic                      phy_power_down_in,        // Physical layer power down
  input  wire logic                      clocklane_pin,            // Clock lane level, async
  input  wire logic                      clocklane_hs_in,          // Clock lane in HS, async
  input  wire logic [NUM_LANES-1:0]      datalane_hs_in,           // Data lanes in HS, async
  input  wire logic [NUM_LANES-1:0]      lane_lp_pos_in,           // LP level p per lane, async
  input  wire logic [NUM_LANES-1:0]      lane_lp_neg_in,           // LP level n per lane, async
  input  wire logic [NUM_LANES*GEAR-1:0] lane_bytes_in,            // Deserialised lane bytes
  input  wire logic                      lane_bytes_valid,         // Lane bytes present
  output logic                           phy_active,               // Physical layer out of reset
  output logic                           byte_clk_out,             // Data-lane derived byte clock
  output logic                           clocklane_hs_derived_clk, // Clock-lane HS byte clock
  output logic                           sync_found_flag,          // Sync seen until LP-11
  output logic                           capture_valid_flag,       // Qualifies raw lane words
  output logic                           payload_valid,            // Payload word strobe
  output logic [NUM_LANES*GEAR-1:0]      payload_word,             // Long packet payload
  output logic [5:0]                     pkt_type_field,           // Header data type
  output logic [1:0]                     pkt_channel_id,           // Header virtual channel
  output logic [15:0]                    pkt_count_field,          // Word count or short data
  output logic [7:0]                     pkt_header_check,         // Header check byte
  output logic [5:0]                     second_pkt_type_field,    // Second header data type
  output logic [1:0]                     second_pkt_channel_id,    // Second header channel
  output logic [15:0]                    second_pkt_count_field,   // Second header count
  output logic [7:0]                     second_pkt_header_check,  // Second header check
  output logic [31:0]                    combined_lane_bytes,      // Four lane bytes, gear 8
  output logic [GEAR-1:0]                raw_lane0_word,           // Raw lane 0 word
  output logic [GEAR-1:0]                raw_lane1_word,           // Raw lane 1 word
  output logic [GEAR-1:0]                raw_lane2_word,           // Raw lane 2 word
  output logic [NUM_LANES-1:0]           lowpower_pos_level,       // Synced LP p levels
  output logic [NUM_LANES-1:0]           lowpower_neg_level        // Synced LP n levels
);

  localparam int W    = NUM_LANES * GEAR;
  localparam int BPW  = W / 8;
  localparam int HALF = ((GEAR == 8) ? SLRXP_DIV_GEAR8 : SLRXP_DIV_GEAR16) / 2;
  localparam int SW   = 2 + 3 * NUM_LANES;
  localparam logic [15:0] BPW16  = 16'(BPW);
  localparam logic [2:0]  HALF_M = 3'(HALF - 1);
  localparam bit          COMB_ON = PARSER_EN && (GEAR == 8) && (W >= 32);
  // Header word split into named fields
  function automatic slrxp_hdr_t decode_hdr(input logic [SLRXP_HDR_BITS-1:0] w);
    slrxp_hdr_t h;
    h.dt  = w[SLRXP_DT_LSB +: 6];
    h.vc  = w[SLRXP_VC_LSB +: 2];
    h.wc  = w[SLRXP_WC_LSB +: 16];
    h.ecc = w[SLRXP_ECC_LSB +: 8];
    return h;
  endfunction
  // Reset release, two stages; freerun reset is trusted as already synchronous
  logic [1:0] rst_q;
  logic       rst_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rst_q <= 2'b00;
    else          rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1] & freerun_domain_rst_n;
  // Power down clears the physical layer at once, release waits two edges
  logic       phy_clr_n;
  logic [1:0] phy_q;
  logic       phy_rst_n;
  assign phy_clr_n = reset_n & ~phy_power_down_in;
  always_ff @(posedge clk or negedge phy_clr_n) begin
    if (!phy_clr_n) phy_q <= 2'b00;
    else            phy_q <= {phy_q[0], 1'b1};
  end
  assign phy_rst_n  = phy_q[1];
  assign phy_active = phy_q[1];
  // Pin synchronisers; first stage read only by the second
  logic [SW-1:0] pin_s1;
  logic [SW-1:0] pin_s2;
  logic          cl_q3;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      cl_q3  <= 1'b0;
    end else begin
      pin_s1 <= {clocklane_pin, clocklane_hs_in, datalane_hs_in, lane_lp_pos_in, lane_lp_neg_in};
      pin_s2 <= pin_s1;
      cl_q3  <= pin_s2[SW-1];
    end
  end

  logic                 cl_level;
  logic                 cl_hs;
  logic                 cl_rise;
  logic                 dl_hs;
  logic [NUM_LANES-1:0] lp_p_s;
  logic [NUM_LANES-1:0] lp_n_s;
  logic [NUM_LANES-1:0] lp11;
  logic                 lp11_end;
  assign cl_level = pin_s2[SW-1];
  assign cl_hs    = pin_s2[SW-2];
  assign dl_hs    = pin_s2[2*NUM_LANES];
  assign lp_p_s   = pin_s2[NUM_LANES +: NUM_LANES];
  assign lp_n_s   = pin_s2[0 +: NUM_LANES];
  assign cl_rise  = cl_level & ~cl_q3;
  assign lp11     = lp_p_s & lp_n_s;
  // Soft layer ends on any lane, hardened one watches lane 0 only
  assign lp11_end = SOFT_PHY ? (|lp11) : lp11[0];

  // Synced LP levels out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowpower_pos_level <= '0;
      lowpower_neg_level <= '0;
    end else begin
      lowpower_pos_level <= lp_p_s;
      lowpower_neg_level <= lp_n_s;
    end
  end

  // Byte clocks: count sampled clock-lane edges; lane clock must stay under clk/2
  logic [1:0] div_gate;
  logic [2:0] div_cnt [2];
  logic [1:0] div_clk;
  assign div_gate[0] = dl_hs;
  assign div_gate[1] = SOFT_PHY ? dl_hs : cl_hs;
  for (genvar g = 0; g < 2; g++) begin : g_div
    always_ff @(posedge clk or negedge phy_rst_n) begin
      if (!phy_rst_n) begin
        div_cnt[g] <= 3'h0;
        div_clk[g] <= 1'b0;
      end else if (!div_gate[g]) begin
        div_cnt[g] <= 3'h0;
        div_clk[g] <= 1'b0;
      end else if (cl_rise) begin
        if (div_cnt[g] == HALF_M) begin
          div_cnt[g] <= 3'h0;
          div_clk[g] <= ~div_clk[g];
        end else begin
          div_cnt[g] <= div_cnt[g] + 3'h1;
        end
      end
    end
  end
  assign byte_clk_out             = div_clk[0];
  assign clocklane_hs_derived_clk = div_clk[1];
  // Sync detect: set beats the LP-11 clear if both land together
  logic sync_set;
  assign sync_set = phy_active && dl_hs && lane_bytes_valid && !sync_found_flag
                    && (lane_bytes_in[7:0] == SLRXP_SYNC_BYTE);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_found_flag    <= 1'b0;
      capture_valid_flag <= 1'b0;
    end else if (sync_set) begin
      sync_found_flag    <= 1'b1;
      capture_valid_flag <= !PARSER_EN;
    end else if (lp11_end) begin
      sync_found_flag    <= 1'b0;
      capture_valid_flag <= 1'b0;
    end
  end

  // Raw lane words and combined bytes; registered so B8 lines up with the flag
  logic [GEAR-1:0] raw [3];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      raw                 <= '{default: '0};
      combined_lane_bytes <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < 3; i++) begin
        raw[i] <= (!PARSER_EN && i < NUM_LANES) ? lane_bytes_in[i*GEAR +: GEAR] : '0;
      end
      combined_lane_bytes <= COMB_ON ? lane_bytes_in[31:0] : 32'h0000_0000;
    end
  end
  assign raw_lane0_word = raw[0];
  assign raw_lane1_word = raw[1];
  assign raw_lane2_word = raw[2];

  // Packet state and remaining payload bytes
  slrxp_pstate_t pstate;
  logic [15:0]   remain;
  logic          hdr_take;
  slrxp_hdr_t    hdr_now;
  assign hdr_now  = decode_hdr(lane_bytes_in[SLRXP_HDR_BITS-1:0]);
  assign hdr_take = (pstate == PS_HEADER) && lane_bytes_valid && !lp11_end;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pstate <= PS_HUNT;
      remain <= 16'h0000;
    end else begin
      unique case (pstate)
        PS_HUNT: begin
          if (sync_set && PARSER_EN) pstate <= PS_HEADER;
        end
        PS_HEADER: begin
          if (lp11_end) begin
            pstate <= PS_HUNT;
          end else if (lane_bytes_valid) begin
            if (hdr_now.dt >= SLRXP_LONG_DT_MIN && hdr_now.wc != 16'h0000) begin
              pstate <= PS_PAYLOAD;
              remain <= hdr_now.wc;
            end else begin
              pstate <= PS_TRAIL;
            end
          end
        end
        PS_PAYLOAD: begin
          if (lp11_end) begin
            pstate <= PS_HUNT;
          end else if (lane_bytes_valid) begin
            if (remain <= BPW16) begin
              pstate <= PS_TRAIL;
              remain <= 16'h0000;
            end else begin
              remain <= remain - BPW16;
            end
          end
        end
        PS_TRAIL: begin
          if (lp11_end) pstate <= PS_HUNT;
        end
      endcase
    end
  end

  // Payload on the free-running clock; checksum bytes in the last word blanked
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      payload_valid <= 1'b0;
      payload_word  <= '0;
    end else begin
      payload_valid <= 1'b0;
      if (pstate == PS_PAYLOAD && lane_bytes_valid && !lp11_end) begin
        payload_valid <= 1'b1;
        for (int i = 0; i < BPW; i++) begin
          payload_word[i*8 +: 8] <= (16'(i) < remain) ? lane_bytes_in[i*8 +: 8] : 8'h00;
        end
      end
    end
  end

  // Header fields held until the next header is taken
  slrxp_hdr_t hdr;
  slrxp_hdr_t hdr2;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hdr  <= SLRXP_HDR_RST;
      hdr2 <= SLRXP_HDR_RST;
    end else if (hdr_take) begin
      hdr <= hdr_now;
      if (W == SLRXP_DUAL_HDR_W) begin
        hdr2 <= decode_hdr(lane_bytes_in[W-1 -: SLRXP_HDR_BITS]);
      end
    end
  end
  assign pkt_type_field          = hdr.dt;
  assign pkt_channel_id          = hdr.vc;
  assign pkt_count_field         = hdr.wc;
  assign pkt_header_check        = hdr.ecc;
  assign second_pkt_type_field   = hdr2.dt;
  assign second_pkt_channel_id   = hdr2.vc;
  assign second_pkt_count_field  = hdr2.wc;
  assign second_pkt_header_check = hdr2.ecc;

  // Checks
  a_pd_clears_phy: assert property (@(posedge clk) disable iff (!rst_n)
    phy_power_down_in |=> !phy_active ##1 !byte_clk_out)
    else $error("power down did not hold the physical layer in reset");
  a_byteclk_gated: assert property (@(posedge clk) disable iff (!rst_n)
    !dl_hs |=> !byte_clk_out)
    else $error("byte clock ran outside data-lane HS");
  a_byteclk_edges: assert property (@(posedge clk) disable iff (!rst_n)
    (phy_active && $changed(byte_clk_out) && $past(div_gate[0])) |-> $past(cl_rise))
    else $error("byte clock toggled without a clock-lane edge");
  a_hsclk_gated: assert property (@(posedge clk) disable iff (!rst_n)
    !div_gate[1] |=> !clocklane_hs_derived_clk)
    else $error("clock-lane byte clock ran outside HS");
  a_soft_same_clk: assert property (@(posedge clk) disable iff (!rst_n)
    SOFT_PHY |-> (clocklane_hs_derived_clk == byte_clk_out))
    else $error("soft layer byte clocks differ");
  a_sync_rise: assert property (@(posedge clk) disable iff (!rst_n)
    sync_set |=> sync_found_flag && (PARSER_EN || raw_lane0_word[7:0] == SLRXP_SYNC_BYTE))
    else $error("sync flag not raised with the sync byte");
  a_sync_fall: assert property (@(posedge clk) disable iff (!rst_n)
    (sync_found_flag && lp11_end && !sync_set) |=> !sync_found_flag)
    else $error("sync flag outlived LP-11");
  a_capture_match: assert property (@(posedge clk) disable iff (!rst_n)
    capture_valid_flag == (sync_found_flag && !PARSER_EN))
    else $error("capture valid differs from sync flag");
  a_payload_only: assert property (@(posedge clk) disable iff (!rst_n)
    payload_valid |-> $past(pstate) == PS_PAYLOAD && $past(remain) != 16'h0000)
    else $error("payload strobe outside payload");
  a_payload_bytes: assert property (@(posedge clk) disable iff (!rst_n)
    (payload_valid && $past(remain) >= BPW16) |-> payload_word == $past(lane_bytes_in))
    else $error("payload bytes reordered or altered");
  a_hdr_fields: assert property (@(posedge clk) disable iff (!rst_n)
    hdr_take |=> pkt_type_field == $past(lane_bytes_in[5:0])
                 && pkt_count_field == $past(lane_bytes_in[23:8])
                 && pkt_header_check == $past(lane_bytes_in[31:24]))
    else $error("header fields not taken from the header word");
  a_hdr_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !hdr_take |=> $stable(pkt_count_field) && $stable(pkt_type_field))
    else $error("header fields changed between headers");

  c_sync_seen:   cover property (@(posedge clk) disable iff (!rst_n) $rose(sync_found_flag));
  c_long_packet: cover property (@(posedge clk) disable iff (!rst_n)
    payload_valid ##1 !payload_valid);
  c_short_pkt:   cover property (@(posedge clk) disable iff (!rst_n)
    hdr_take && hdr_now.dt < SLRXP_LONG_DT_MIN);
  c_burst_end:   cover property (@(posedge clk) disable iff (!rst_n) $fell(sync_found_flag));

endmodule

// file: sim/slrxp_lane_src.sv
// Behavioural camera-side source for four gear-8 lanes
module slrxp_lane_src (
  input  wire logic        clk,     // Byte clock
  output logic             clk_pin, // Clock lane level
  output logic             clk_hs,  // Clock lane in HS
  output logic [3:0]       data_hs, // Data lanes in HS
  output logic [3:0]       lp_pos,  // LP p levels
  output logic [3:0]       lp_neg,  // LP n levels
  output logic [31:0]      bytes,   // Lane bytes
  output logic             valid    // Bytes present
);
  timeunit 1ns;
  timeprecision 100ps;

  // Lanes rest in LP-11, lane clock still
  initial begin
    clk_pin = 1'b0;
    clk_hs = 1'b0;
    data_hs = 4'h0;
    lp_pos = 4'hf;
    lp_neg = 4'hf;
    bytes = 32'h0;
    valid = 1'b0;
  end

  // One lane word per clock; idle words invert so stale data never looks valid
  task automatic put(input logic [31:0] w, input logic v);
    @(posedge clk);
    #1;
    bytes = v ? w : ~bytes;
    valid = v;
  endtask

  // Leave LP-11; settle through the pin synchronisers
  task automatic enter_hs();
    @(posedge clk);
    #1;
    lp_pos = 4'h0;
    lp_neg = 4'h0;
    data_hs = 4'hf;
    clk_hs = 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // End of burst: back to LP-11
  task automatic exit_hs();
    @(posedge clk);
    #1;
    valid = 1'b0;
    data_hs = 4'h0;
    clk_hs = 1'b0;
    lp_pos = 4'hf;
    lp_neg = 4'hf;
  endtask

  // Lane clock kept below half the byte clock so no edge is lost
  task automatic clock_edges(input int n);
    repeat (n) begin
      repeat (2) @(posedge clk);
      #1;
      clk_pin = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      clk_pin = 1'b0;
    end
  endtask
endmodule

// file: sim/tb.sv
module tb;
  import slrxp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk;
  logic        reset_n;
  logic        fr_rst_n;
  logic        pd;
  logic        c_pin;
  logic        c_hs;
  logic [3:0]  d_hs;
  logic [3:0]  lp_p;
  logic [3:0]  lp_n;
  logic [31:0] lbytes;
  logic        lvalid;
  logic        phy_active;
  logic        bclk;
  logic        hs_clk;
  logic        sync;
  logic        cap_valid;
  logic        pvalid;
  logic [31:0] pword;
  logic [5:0]  dt;
  logic [1:0]  vc;
  logic [15:0] wc;
  logic [7:0]  ecc;
  logic [15:0] wc2;
  logic [5:0]  dt2;
  logic [1:0]  vc2;
  logic [7:0]  ecc2;
  logic [7:0]  raw0;
  logic [7:0]  raw1;
  logic [7:0]  raw2;
  logic [31:0] comb;
  logic [3:0]  lp_lvl;
  logic [3:0]  lp_n_lvl;
  logic        bclk_prev;
  int          n_errors = 0;
  int          checked = 0;
  int          cycles = 0;
  int          toggles = 0;
  int          clk_diff = 0;

  slrxp_lane_src SRC (.clk(clk), .clk_pin(c_pin), .clk_hs(c_hs), .data_hs(d_hs),
    .lp_pos(lp_p), .lp_neg(lp_n), .bytes(lbytes), .valid(lvalid));

  slrxp_top #(.NUM_LANES(4), .GEAR(8), .PARSER_EN(1'b1), .SOFT_PHY(1'b1)) DUT (
    .clk(clk), .reset_n(reset_n), .freerun_domain_rst_n(fr_rst_n), .phy_power_down_in(pd),
    .clocklane_pin(c_pin), .clocklane_hs_in(c_hs), .datalane_hs_in(d_hs),
    .lane_lp_pos_in(lp_p), .lane_lp_neg_in(lp_n), .lane_bytes_in(lbytes),
    .lane_bytes_valid(lvalid), .phy_active(phy_active), .byte_clk_out(bclk),
    .clocklane_hs_derived_clk(hs_clk), .sync_found_flag(sync), .capture_valid_flag(cap_valid),
    .payload_valid(pvalid), .payload_word(pword), .pkt_type_field(dt), .pkt_channel_id(vc),
    .pkt_count_field(wc), .pkt_header_check(ecc), .second_pkt_type_field(dt2),
    .second_pkt_channel_id(vc2), .second_pkt_count_field(wc2), .second_pkt_header_check(ecc2),
    .combined_lane_bytes(comb), .raw_lane0_word(raw0), .raw_lane1_word(raw1),
    .raw_lane2_word(raw2), .lowpower_pos_level(lp_lvl), .lowpower_neg_level(lp_n_lvl));

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Watch the derived clocks; also the hang guard
  always @(posedge clk) begin
    if (bclk !== bclk_prev) toggles++;
    if (bclk !== hs_clk) clk_diff++;
    bclk_prev = bclk;
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Lane clock divided by four only while data lanes are in HS
  task automatic test_byte_clk();
    SRC.enter_hs();
    toggles = 0;
    clk_diff = 0;
    SRC.clock_edges(8);
    repeat (6) @(posedge clk);
    chk(32'(toggles), 32'h4);
    chk(32'(clk_diff), 32'h0);
    SRC.exit_hs();
    repeat (4) @(posedge clk);
    toggles = 0;
    SRC.clock_edges(4);
    repeat (6) @(posedge clk);
    chk(32'(toggles), 32'h0);
  endtask

  // Power-down clears the physical layer at once, even with the byte clock high
  task automatic test_power_down();
    SRC.enter_hs();
    SRC.clock_edges(2);
    repeat (2) @(posedge clk);
    #1;
    chk_bit(bclk, 1'b1);
    pd = 1'b1;
    #1;
    chk_bit(phy_active, 1'b0);
    chk_bit(bclk, 1'b0);
    @(posedge clk);
    #1;
    pd = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk_bit(phy_active, 1'b1);
    SRC.exit_hs();
  endtask

  // Six-byte long packet: last word carries two payload and two checksum bytes
  task automatic test_long();
    SRC.enter_hs();
    SRC.put(32'h3c2d1eb8, 1'b1);
    SRC.put(32'h5c00066a, 1'b1);
    chk_bit(sync, 1'b1);
    chk(32'({lp_n_lvl, lp_lvl}), 32'h0);
    SRC.put(32'h44332211, 1'b1);
    chk(32'(dt), 32'h2a);
    chk(32'(vc), 32'h1);
    chk(32'(wc), 32'h6);
    chk(32'(ecc), 32'h5c);
    chk(32'(wc2), 32'h0);
    chk(32'({ecc2, vc2, dt2}), 32'h0);
    chk(32'({raw2, raw1, raw0}), 32'h0);
    chk(comb, 32'h5c00066a);
    chk_bit(pvalid, 1'b0);
    SRC.put(32'hc1c06655, 1'b1);
    chk_bit(pvalid, 1'b1);
    chk(pword, 32'h44332211);
    SRC.put(32'h77777777, 1'b1);
    chk_bit(pvalid, 1'b1);
    chk(pword, 32'h00006655);
    SRC.put(32'h0, 1'b0);
    chk_bit(pvalid, 1'b0);
    chk_bit(sync, 1'b1);
    chk_bit(cap_valid, 1'b0);
    SRC.exit_hs();
    @(posedge clk);
    #1;
    chk_bit(sync, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    chk_bit(sync, 1'b0);
    chk(32'(lp_lvl), 32'hf);
    chk(32'(lp_n_lvl), 32'hf);
    chk(32'(dt), 32'h2a);
  endtask

  // Short packet: count field carries the two data bytes, nothing strobed
  task automatic test_short();
    SRC.enter_hs();
    SRC.put(32'h00000cb8, 1'b1);
    SRC.put(32'h3bbeef81, 1'b1);
    SRC.put(32'h11111111, 1'b1);
    chk(32'(wc), 32'hbeef);
    chk(32'(dt), 32'h01);
    chk(32'(vc), 32'h2);
    chk(32'(ecc), 32'h3b);
    SRC.put(32'h0, 1'b0);
    chk_bit(pvalid, 1'b0);
    SRC.exit_hs();
    repeat (4) @(posedge clk);
    #1;
    // Domain reset is driven right after an edge, as a synchronous source would
    fr_rst_n = 1'b0;
    #1;
    chk(32'(wc), 32'(SLRXP_WC_RST));
    @(posedge clk);
    #1;
    fr_rst_n = 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // Main sequence
  initial begin
    reset_n = 1'b0;
    fr_rst_n = 1'b1;
    pd = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk_bit(sync, 1'b0);
    chk_bit(phy_active, 1'b1);
    test_byte_clk();
    test_power_down();
    test_long();
    test_short();
    complete_run();
  end
endmodule
